// *** logic/ofd_regs.sv ***
// Offset monitor and 48 kHz frame rate detect register bank
// ****************************************
// Overview of operation
// - Left differential loop offset: MSB in 0x4C bit 0, low byte in 0x4D.
// - Left common-mode loop offset: MSB in 0x54 bit 0, low byte 0x55, read only.
// - Monitor codes are signed two's complement, 0.25 mV per step.
// - Code range spans +63.75 mV down to -64.0 mV.
// - 0x4E bits 4:0 hold the read/write lower count bound, reset zero.
// - 0x50 bits 4:0 hold the read/write upper count bound, reset zero.
// - 0x4F, 0x51-0x53, 0x56, 0x57 are plain reserved read/write bytes, reset zero.
// ****************************************
`timescale 1ns/1ps
module ofd_regs #(
    parameter int SHIFT = ofd_pkg::BOUND_SHIFT
) (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic                         reg_wr_en,
    input  wire logic [7:0]                   reg_wr_data,
    input  wire logic                         reg_rd_en,
    output logic      [7:0]                   reg_rd_data_reg,
    input  wire logic [ofd_pkg::MON_WIDTH-1:0] differential_loop_offset,
    input  wire logic [ofd_pkg::MON_WIDTH-1:0] common_mode_feedback_loop_offset,
    input  wire logic                         frame_clk,
    output logic                              rate48_detected_reg
);
    import ofd_pkg::*;

    logic [7:0] bank_reg [BANK_DEPTH];
    logic [7:0] read_next;
    logic [3:0] idx;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic in_bank(input logic [7:0] a);
        in_bank = (a >= FIRST_OFS) && (a <= LAST_OFS);
    endfunction

    // Low monitor bytes have no storage behind them
    function automatic logic is_monitor_low(input logic [7:0] a);
        is_monitor_low = (a == DIFFERENTIAL_LOOP_LOW_OFS) || (a == CM_LOW_OFS);
    endfunction

    assign idx = 4'(reg_addr - FIRST_OFS);

    // ****************************************
    // Writable bytes
    // ****************************************
    // Bit 0 of the two MSB bytes is stored but never read back
    generate
        for (genvar i = 0; i < BANK_DEPTH; i++) begin : g_bank
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    bank_reg[i] <= BYTE_RESET;
                end else if (reg_wr_en && in_bank(reg_addr) && !is_monitor_low(reg_addr)
                             && idx == 4'(i)) begin
                    bank_reg[i] <= reg_wr_data;
                end
            end
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    // Monitor codes pass untouched: the two's complement code is the reading
    always_comb begin
        read_next = UNMAPPED_READ;
        if (reg_addr == DIFFERENTIAL_LOOP_MSB_OFS) begin
            read_next = {bank_reg[idx][7:1], differential_loop_offset[MON_WIDTH-1]};
        end else if (reg_addr == DIFFERENTIAL_LOOP_LOW_OFS) begin
            read_next = differential_loop_offset[7:0];
        end else if (reg_addr == CM_MSB_OFS) begin
            read_next = {bank_reg[idx][7:1], common_mode_feedback_loop_offset[MON_WIDTH-1]};
        end else if (reg_addr == CM_LOW_OFS) begin
            read_next = common_mode_feedback_loop_offset[7:0];
        end else if (in_bank(reg_addr)) begin
            read_next = bank_reg[idx];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rd_data_reg <= UNMAPPED_READ;
        end else if (reg_rd_en) begin
            reg_rd_data_reg <= read_next;
        end
    end

    // ****************************************
    // Rate detector
    // ****************************************
    ofd_rate_detect #(
        .COUNT_W (COUNT_WIDTH),
        .SHIFT   (SHIFT)
    ) u_rate (
        .sys_clk             (sys_clk),
        .resetn              (resetn),
        .frame_clk           (frame_clk),
        .lower_bound         (bank_reg[4'(LOWER_OFS - FIRST_OFS)][BOUND_LSB +: BOUND_WIDTH]),
        .upper_bound         (bank_reg[4'(UPPER_OFS - FIRST_OFS)][BOUND_LSB +: BOUND_WIDTH]),
        .rate48_detected_reg (rate48_detected_reg)
    );

    // ****************************************
    // Checks
    // ****************************************
    sequence rd_at(logic [7:0] a);
        reg_rd_en && reg_addr == a;
    endsequence

    sequence wr_then_rd(logic [7:0] a);
        (reg_wr_en && reg_addr == a) ##1 (reg_rd_en && !reg_wr_en && reg_addr == a);
    endsequence

    sequence code_rd(logic [7:0] a, logic [8:0] c);
        rd_at(a) ##0 differential_loop_offset == c;
    endsequence

    differential_loop_low_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_at(DIFFERENTIAL_LOOP_LOW_OFS) |=> reg_rd_data_reg == $past(differential_loop_offset[7:0]))
        else $error("differential_loop low byte readback wrong");

    differential_loop_msb_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_at(DIFFERENTIAL_LOOP_MSB_OFS) |=> reg_rd_data_reg[MON_MSB_BIT] == $past(differential_loop_offset[8]))
        else $error("differential_loop msb readback wrong");

    cm_monitor_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_at(CM_LOW_OFS) or rd_at(CM_MSB_OFS) |=> reg_rd_data_reg[0] ==
            ($past(reg_addr) == CM_LOW_OFS ? $past(common_mode_feedback_loop_offset[0])
                                           : $past(common_mode_feedback_loop_offset[8])))
        else $error("common mode readback wrong");

    monitor_no_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(CM_LOW_OFS) |=> reg_rd_data_reg == $past(common_mode_feedback_loop_offset[7:0]))
        else $error("write reached a monitor byte");

    minus_one_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        code_rd(DIFFERENTIAL_LOOP_LOW_OFS, 9'h1ff) |=> reg_rd_data_reg == 8'hff)
        else $error("all ones code not passed through");

    most_negative_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        code_rd(DIFFERENTIAL_LOOP_MSB_OFS, 9'h100) |=> reg_rd_data_reg[0] == 1'b1)
        else $error("most negative code sign lost");

    lower_bound_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(LOWER_OFS) |=> reg_rd_data_reg == $past(reg_wr_data, 2))
        else $error("lower bound readback wrong");

    upper_bound_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(UPPER_OFS) |=> reg_rd_data_reg == $past(reg_wr_data, 2))
        else $error("upper bound readback wrong");

    reserved_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(RSVD_E_OFS) |=> reg_rd_data_reg == $past(reg_wr_data, 2))
        else $error("reserved byte readback wrong");

    unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_rd_en && !in_bank(reg_addr) |=> reg_rd_data_reg == UNMAPPED_READ)
        else $error("unmapped read not zero");

    // ****************************************
    // Checks: reset, hold and last reserved byte
    // ****************************************
    // Read data holds between strobes so a slow host may fetch it late
    rd_data_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !reg_rd_en |=> $stable(reg_rd_data_reg))
        else $error("read data moved without a read strobe");

    read_reset_a: assert property (@(posedge sys_clk)
        !resetn |=> reg_rd_data_reg == UNMAPPED_READ)
        else $error("read data not cleared by reset");

    bound_reset_a: assert property (@(posedge sys_clk)
        !resetn |=> bank_reg[4'(LOWER_OFS - FIRST_OFS)] == BYTE_RESET
            && bank_reg[4'(UPPER_OFS - FIRST_OFS)] == BYTE_RESET)
        else $error("count bounds not cleared by reset");

    reserved_last_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(RSVD_F_OFS) |=> reg_rd_data_reg == $past(reg_wr_data, 2))
        else $error("last reserved byte readback wrong");

    // ****************************************
    // Checks: monitor bytes
    // ****************************************
    cm_low_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_at(CM_LOW_OFS) |=> reg_rd_data_reg == $past(common_mode_feedback_loop_offset[7:0]))
        else $error("common mode low byte readback wrong");

    cm_msb_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_at(CM_MSB_OFS) |=> reg_rd_data_reg[MON_MSB_BIT] == $past(common_mode_feedback_loop_offset[8]))
        else $error("common mode msb readback wrong");

    differential_loop_low_no_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(DIFFERENTIAL_LOOP_LOW_OFS) |=> reg_rd_data_reg == $past(differential_loop_offset[7:0]))
        else $error("write reached the differential_loop low byte");

    differential_loop_msb_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(DIFFERENTIAL_LOOP_MSB_OFS) |=> reg_rd_data_reg[7:1] == $past(reg_wr_data[7:1], 2))
        else $error("differential_loop msb reserved bits not kept");

    cm_msb_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_then_rd(CM_MSB_OFS) |=> reg_rd_data_reg[7:1] == $past(reg_wr_data[7:1], 2))
        else $error("common mode msb reserved bits not kept");

    plus_one_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        code_rd(DIFFERENTIAL_LOOP_LOW_OFS, 9'h001) |=> reg_rd_data_reg == 8'h01)
        else $error("plus one code not passed through");

    zero_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        code_rd(DIFFERENTIAL_LOOP_LOW_OFS, 9'h000) |=> reg_rd_data_reg == 8'h00)
        else $error("zero code not passed through");

    most_positive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        code_rd(DIFFERENTIAL_LOOP_MSB_OFS, 9'h0ff) |=> reg_rd_data_reg[0] == 1'b0)
        else $error("most positive code sign wrong");

    near_negative_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        code_rd(DIFFERENTIAL_LOOP_LOW_OFS, 9'h101) |=> reg_rd_data_reg == 8'h01)
        else $error("step above most negative code wrong");

endmodule

// *** shared/ofd_pkg.sv ***
// Constants shared by the offset monitor and frame rate detect register bank
package ofd_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] DIFFERENTIAL_LOOP_MSB_OFS  = 8'h4c;
    localparam logic [7:0] DIFFERENTIAL_LOOP_LOW_OFS  = 8'h4d;
    localparam logic [7:0] LOWER_OFS     = 8'h4e;
    localparam logic [7:0] RSVD_A_OFS    = 8'h4f;
    localparam logic [7:0] UPPER_OFS     = 8'h50;
    localparam logic [7:0] RSVD_B_OFS    = 8'h51;
    localparam logic [7:0] RSVD_C_OFS    = 8'h52;
    localparam logic [7:0] RSVD_D_OFS    = 8'h53;
    localparam logic [7:0] CM_MSB_OFS    = 8'h54;
    localparam logic [7:0] CM_LOW_OFS    = 8'h55;
    localparam logic [7:0] RSVD_E_OFS    = 8'h56;
    localparam logic [7:0] RSVD_F_OFS    = 8'h57;
    localparam logic [7:0] FIRST_OFS     = DIFFERENTIAL_LOOP_MSB_OFS;
    localparam logic [7:0] LAST_OFS      = RSVD_F_OFS;
    localparam int         BANK_DEPTH    = 12;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int         MON_WIDTH     = 9;
    localparam int         MON_MSB_BIT   = 0;
    localparam int         BOUND_LSB     = 0;
    localparam int         BOUND_WIDTH   = 5;
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************
    // Rate detector sizing
    // ****************************************
    localparam int         COUNT_WIDTH   = 12;
    localparam int         BOUND_SHIFT   = 7;
    localparam int         LOWER_NOMINAL = 863;
    localparam int         UPPER_NOMINAL = 2479;

endpackage

// *** logic/ofd_rate_detect.sv ***
// Frame clock rate detector: counts oscillator cycles per frame clock period
`timescale 1ns/1ps
module ofd_rate_detect #(
    parameter int COUNT_W = ofd_pkg::COUNT_WIDTH,
    parameter int SHIFT   = ofd_pkg::BOUND_SHIFT
) (
    input  wire logic                           sys_clk,
    input  wire logic                           resetn,
    input  wire logic                           frame_clk,
    input  wire logic [ofd_pkg::BOUND_WIDTH-1:0] lower_bound,
    input  wire logic [ofd_pkg::BOUND_WIDTH-1:0] upper_bound,
    output logic                                rate48_detected_reg
);
    import ofd_pkg::*;

    logic               frame_meta_reg;
    logic               frame_sync_reg;
    logic               frame_last_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic               period_end;
    logic [COUNT_W-1:0] scaled;

    // ****************************************
    // Pin synchroniser
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            frame_meta_reg <= 1'b0;
            frame_sync_reg <= 1'b0;
            frame_last_reg <= 1'b0;
        end else begin
            frame_meta_reg <= frame_clk;
            frame_sync_reg <= frame_meta_reg;
            frame_last_reg <= frame_sync_reg;
        end
    end

    assign period_end = frame_sync_reg && !frame_last_reg;
    assign scaled     = count_reg >> SHIFT;

    // ****************************************
    // Period counter
    // ****************************************
    // Saturates so a stopped frame clock never wraps into the window
    always_comb begin
        count_next = count_reg;
        if (period_end) begin
            count_next = {{(COUNT_W-1){1'b0}}, 1'b1};
        end else if (count_reg != {COUNT_W{1'b1}}) begin
            count_next = count_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Bounds are coarse: compared against the count divided by 2**SHIFT
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rate48_detected_reg <= 1'b0;
        end else if (period_end) begin
            rate48_detected_reg <= (scaled >= COUNT_W'(lower_bound)) && (scaled <= COUNT_W'(upper_bound));
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    detect_window_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        period_end |=> rate48_detected_reg ==
            (($past(scaled) >= COUNT_W'($past(lower_bound))) && ($past(scaled) <= COUNT_W'($past(upper_bound)))))
        else $error("rate flag disagrees with bounds");

    detect_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !period_end |=> $stable(rate48_detected_reg))
        else $error("rate flag changed between frame edges");

    count_restart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        period_end |=> count_reg == {{(COUNT_W-1){1'b0}}, 1'b1})
        else $error("period count did not restart");

endmodule

// *** verification/ofd_host_model.sv ***
// Host side model: register byte port master and frame clock source
`timescale 1ns/1ps
module ofd_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rd_data_reg,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    output logic            frame_clk
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
        frame_clk = 1'b0;
    end
    // ****************************************
    // Byte transfers, one strobe cycle each
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        // Data no longer qualified: show the inverse so stale values cannot match
        reg_wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
        d = reg_rd_data_reg;
    endtask
    // Write then read of one address on back to back edges
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_wr_data <= ~d;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
        q = reg_rd_data_reg;
    endtask
    // Three rising edges n cycles apart, then the pin stands low
    task automatic frame(input int n);
        repeat (3) begin
            @(posedge sys_clk);
            frame_clk <= 1'b1;
            repeat (n / 2) @(posedge sys_clk);
            frame_clk <= 1'b0;
            repeat (n - n / 2 - 1) @(posedge sys_clk);
        end
    endtask
endmodule

// *** verification/offset_monitor_fs_detect_regs_bench.sv ***
// Self-checking bench for the offset monitor and rate detect register bank
`timescale 1ns/1ps
module offset_monitor_fs_detect_regs_bench;
    import ofd_pkg::*;
    logic       sys_clk;
    logic       resetn;
    logic [8:0] differential_loop_off;
    logic [8:0] cm_off;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr_en;
    logic       rd_en;
    logic       fclk;
    logic       flag;
    logic [7:0] shadow [12];
    int         bad_count;
    int         samples_checked;
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        resetn = 1'b0;
        differential_loop_off = 9'h155;
        cm_off = 9'h0aa;
        bad_count = 0;
        samples_checked = 0;
    end
    // Bounds compared unshifted so short frame periods hit the edges of the window
    ofd_regs #(.SHIFT(0)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wdata), .reg_rd_en(rd_en), .reg_rd_data_reg(rdata), .differential_loop_offset(differential_loop_off),
        .common_mode_feedback_loop_offset(cm_off), .frame_clk(fclk), .rate48_detected_reg(flag));
    ofd_host_model host (.sys_clk(sys_clk), .reg_rd_data_reg(rdata), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wdata), .reg_rd_en(rd_en), .frame_clk(fclk));
    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == DIFFERENTIAL_LOOP_MSB_OFS) return {shadow[0][7:1], differential_loop_off[8]};
        if (a == DIFFERENTIAL_LOOP_LOW_OFS) return differential_loop_off[7:0];
        if (a == CM_MSB_OFS) return {shadow[8][7:1], cm_off[8]};
        if (a == CM_LOW_OFS) return cm_off[7:0];
        if (a >= FIRST_OFS && a <= LAST_OFS) return shadow[a - FIRST_OFS];
        return UNMAPPED_READ;
    endfunction
    task automatic check_all();
        logic [7:0] d;
        for (int a = 8'h4b; a <= 8'h58; a++) begin
            host.rd(8'(a), d);
            chk8($sformatf("byte %h", a), exp_rd(8'(a)), d);
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        foreach (shadow[i]) shadow[i] = BYTE_RESET;
        check_all();
    endtask
    task automatic t_write(input logic [7:0] pat);
        for (int i = 0; i < BANK_DEPTH; i++) begin
            host.wr(FIRST_OFS + 8'(i), pat ^ 8'(i));
            shadow[i] = pat ^ 8'(i);
        end
        host.wr(8'h58, pat);
        host.wr(8'h4b, pat);
        check_all();
    endtask
    task automatic t_monitor();
        logic [8:0] codes [6] = '{9'h0ff, 9'h100, 9'h101, 9'h1ff, 9'h001, 9'h000};
        logic [7:0] d;
        foreach (codes[i]) begin
            @(posedge sys_clk);
            differential_loop_off <= codes[i];
            cm_off <= ~codes[i];
            host.rd(DIFFERENTIAL_LOOP_MSB_OFS, d);
            chk8("differential_loop msb", {shadow[0][7:1], codes[i][8]}, d);
            host.rd(DIFFERENTIAL_LOOP_LOW_OFS, d);
            chk8("differential_loop low", codes[i][7:0], d);
            host.rd(CM_MSB_OFS, d);
            chk8("cm msb", {shadow[8][7:1], ~codes[i][8]}, d);
            host.rd(CM_LOW_OFS, d);
            chk8("cm low", ~codes[i][7:0], d);
        end
    endtask
    task automatic t_wr_rd();
        logic [7:0] addrs [8] = '{LOWER_OFS, UPPER_OFS, RSVD_E_OFS, RSVD_F_OFS,
                                  DIFFERENTIAL_LOOP_LOW_OFS, CM_LOW_OFS, DIFFERENTIAL_LOOP_MSB_OFS, CM_MSB_OFS};
        logic [7:0] d;
        foreach (addrs[i]) begin
            if (addrs[i] != DIFFERENTIAL_LOOP_LOW_OFS && addrs[i] != CM_LOW_OFS) begin
                shadow[addrs[i] - FIRST_OFS] = 8'h3c ^ 8'(i);
            end
            host.wr_rd(addrs[i], 8'h3c ^ 8'(i), d);
            chk8($sformatf("write then read %h", addrs[i]), exp_rd(addrs[i]), d);
        end
    endtask
    task automatic t_rate();
        int periods [4] = '{9, 10, 20, 21};
        // Upper bits of each bound byte are set to prove only bits 4:0 take part
        host.wr(LOWER_OFS, 8'hea);
        host.wr(UPPER_OFS, 8'hf4);
        foreach (periods[i]) begin
            host.frame(periods[i]);
            chk8("rate flag", {7'h00, periods[i] >= 10 && periods[i] <= 20}, {7'h00, flag});
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_write(8'ha5);
        t_write(8'h5a);
        t_monitor();
        t_wr_rd();
        t_rate();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        chk8("flag after reset", 8'h00, {7'h00, flag});
        t_reset();
        report_and_stop();
    end
endmodule
